// >>> sfi_spi_slave.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - sample serial input on rising clock edges
// R2 - shift stored data out after falling edges
// R3 - select low is active; high means standby
// R4 - status write lock only with protect low
// R5 - hold low suspends, high resumes transfer
// R6 - only clock modes 0 and 3 supported
// R7 - array is 256k bytes, byte addressed
// R8 - erase units 4k small sector, 64k sector
// R9 - one program writes at most one page
// R10 - host waits erase worst case times
// R11 - host waits 5 ms page program
// R12 - host keeps serial clock under 30 MHz
// R13 - every byte travels msb first
// R14 - clock level at select picks mode
// R15 - host ends non read commands whole
// R16 - output released while deselected
// R17 - during hold ignore clocks, release output
// R18 - host polls busy before new commands

// ------------------------------------------------------------
// byte fifo with registered output stage
// ------------------------------------------------------------
module sfi_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // out stage refills whenever it is empty or being drained
  assign in_ready = (count_q != (PW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_q != '0) && (!out_valid || out_ready);

  // storage, no reset needed on the data words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // registered head word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ------------------------------------------------------------
// serial front end
// ------------------------------------------------------------
module sfi_spi_slave #(
  parameter int unsigned DEPTH = sfi_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  input wire logic STATUS_WRITE_LOCK,
  output logic LOCK_ACTIVE,
  input wire logic TX_EN,
  input wire logic [7:0] TX_DATA,
  output logic TX_TAKE,
  output logic RX_VALID,
  input wire logic RX_READY,
  output sfi_pkg::sfi_byte_type RX_BYTE,
  output logic SELECTED,
  output logic MODE3,
  output logic PAGE_END,
  output logic OVERRUN
);
  import sfi_pkg::*;

  sfi_state_type state_q;
  sfi_state_type state_d;
  logic sck_q;
  logic [7:0] rx_shift_q;
  logic [6:0] tx_shift_q;
  logic [2:0] bit_cnt_q;
  logic first_q;
  logic rise_seen_q;
  logic [9:0] frame_cnt_q;
  logic push_q;
  logic rd_on_q;
  sfi_byte_type push_byte_q;
  logic fifo_ready;
  logic active;
  logic sck_rise;
  logic sck_fall;

  // sck is sampled at 250 MHz; an edge counts at the first clock that sees the new level
  assign active = (state_q == SFI_XFER);
  assign sck_rise = active && SCK && !sck_q; // R17
  assign sck_fall = active && !SCK && sck_q; // R17

  // ------------------------------------------------------------
  // selection and hold
  // ------------------------------------------------------------
  // select and hold decide whether clock edges count at all
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFI_IDLE: begin
        if (!CS_N) begin
          state_d = HOLD_N ? SFI_XFER : SFI_HOLD; // R3
        end
      end
      SFI_XFER: begin
        if (CS_N) begin
          state_d = SFI_IDLE; // R3
        end else if (!HOLD_N) begin
          state_d = SFI_HOLD; // R5
        end
      end
      SFI_HOLD: begin
        if (CS_N) begin
          state_d = SFI_IDLE;
        end else if (HOLD_N) begin
          state_d = SFI_XFER; // R5
        end
      end
      default: begin
        state_d = SFI_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= SFI_IDLE;
      sck_q <= 1'b0;
      SELECTED <= 1'b0;
    end else begin
      state_q <= state_d;
      sck_q <= SCK;
      SELECTED <= !CS_N;
    end
  end

  // clock level at the select edge fixes mode 0 or mode 3
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MODE3 <= 1'b0;
    end else if (state_q == SFI_IDLE && !CS_N) begin
      MODE3 <= SCK; // R14 R6
    end
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  // bits enter msb first on rising edges; a partial byte is dropped
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_shift_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      first_q <= 1'b1;
      rise_seen_q <= 1'b0;
      push_q <= 1'b0;
      push_byte_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (state_q == SFI_IDLE) begin
        bit_cnt_q <= 3'h0;
        first_q <= 1'b1;
        rise_seen_q <= 1'b0;
      end else if (sck_rise) begin
        rx_shift_q <= {rx_shift_q[6:0], SI}; // R1 R13
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rise_seen_q <= 1'b1;
        if (bit_cnt_q == BIT_LAST) begin
          push_q <= 1'b1;
          push_byte_q <= '{first: first_q, data: {rx_shift_q[6:0], SI}};
          first_q <= 1'b0;
        end
      end
    end
  end

  // bytes in the frame; the page limit marks where programming stops
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      frame_cnt_q <= FRAME_CNT_RESET;
      PAGE_END <= 1'b0;
    end else if (state_q == SFI_IDLE) begin
      frame_cnt_q <= FRAME_CNT_RESET;
      PAGE_END <= 1'b0;
    end else if (push_q && frame_cnt_q != PAGE_END_CNT) begin
      frame_cnt_q <= frame_cnt_q + 10'h001;
      PAGE_END <= (frame_cnt_q + 10'h001 == PAGE_END_CNT); // R9
    end
  end

  // the host cannot be stalled, so a full buffer is reported instead
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      OVERRUN <= 1'b0;
    end else if (push_q && !fifo_ready) begin
      OVERRUN <= 1'b1;
    end else if (state_q == SFI_IDLE && !CS_N) begin
      OVERRUN <= 1'b0;
    end
  end

  sfi_fifo #(
    .WIDTH($bits(sfi_byte_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .reset(RESET),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(push_byte_q),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_BYTE)
  );

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  // a new byte is loaded on the first falling edge of each byte slot;
  // in mode 3 the falling edge before any rising edge is skipped
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SO <= 1'b0;
      tx_shift_q <= 7'h00;
      TX_TAKE <= 1'b0;
    end else begin
      TX_TAKE <= 1'b0;
      if (sck_fall && rise_seen_q) begin
        if (bit_cnt_q == 3'h0) begin
          SO <= TX_DATA[7]; // R2 R13
          tx_shift_q <= TX_DATA[6:0];
          TX_TAKE <= TX_EN;
        end else begin
          SO <= tx_shift_q[6]; // R2
          tx_shift_q <= {tx_shift_q[5:0], 1'b0};
        end
      end
    end
  end

  // read phase memory; survives a hold so the driver comes back after it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_on_q <= 1'b0;
    end else if (state_q == SFI_IDLE || !TX_EN) begin
      rd_on_q <= 1'b0;
    end else if (sck_fall && rise_seen_q && bit_cnt_q == 3'h0) begin
      rd_on_q <= 1'b1; // R5
    end
  end

  // driver enabled only when selected, not held, and a read is running
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SO_OE <= 1'b0;
    end else if (state_d != SFI_XFER) begin
      SO_OE <= 1'b0; // R16 R17
    end else if (sck_fall && rise_seen_q && bit_cnt_q == 3'h0) begin
      SO_OE <= TX_EN;
    end else begin
      SO_OE <= rd_on_q && TX_EN; // R5
    end
  end

  // protect pin high makes the stored lock bit powerless
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      LOCK_ACTIVE <= 1'b0;
    end else begin
      LOCK_ACTIVE <= STATUS_WRITE_LOCK && !WP_N; // R4
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence rise_s;
    !CS_N && HOLD_N && state_q == SFI_XFER && SCK && !sck_q;
  endsequence

  rx_bit_capture_a: assert property ( // R1
    rise_s |=> rx_shift_q[0] == $past(SI))
    else $error("serial input bit not captured on rising edge");
  tx_bit_fall_a: assert property ( // R2
    (sck_fall && rise_seen_q && bit_cnt_q == 3'h0) |=>
      SO == $past(TX_DATA[7]))
    else $error("output bit not launched on falling edge");
  standby_ignore_a: assert property ( // R3
    (state_q == SFI_IDLE) |=> !push_q && bit_cnt_q == 3'h0)
    else $error("traffic accepted while deselected");
  lock_gate_a: assert property ( // R4
    WP_N |=> !LOCK_ACTIVE)
    else $error("lock active with protect pin high");
  hold_resume_a: assert property ( // R5
    (state_q == SFI_HOLD && HOLD_N && !CS_N) |=> state_q == SFI_XFER)
    else $error("transfer did not resume after hold");
  mode_pick_a: assert property ( // R14
    (state_q == SFI_IDLE && !CS_N) |=> MODE3 == $past(SCK))
    else $error("mode not chosen from clock level at select");
  deselect_release_a: assert property ( // R16
    CS_N |=> !SO_OE)
    else $error("output driven while deselected");
  hold_ignore_a: assert property ( // R17
    (state_q == SFI_HOLD) [*2] |-> $stable(bit_cnt_q) && !SO_OE)
    else $error("clock edges counted or output driven during hold");
  byte_msb_a: assert property ( // R13
    (rise_s and bit_cnt_q == BIT_LAST) |=>
      push_q && push_byte_q.data[0] == $past(SI))
    else $error("byte not assembled msb first");
  page_limit_a: assert property ( // R9
    PAGE_END |-> frame_cnt_q == PAGE_END_CNT)
    else $error("page end flagged at wrong byte count");
endmodule

// >>> sfi_pkg.sv
package sfi_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int unsigned ARRAY_BYTES = 262144; // R7
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned SMALL_SECTOR_BYTES = 4096;
  localparam int unsigned SECTOR_BYTES = 65536; // R8
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned SMALL_SECTOR_SHIFT = 12;
  localparam int unsigned SECTOR_SHIFT = 16;

  // ------------------------------------------------------------
  // framing and buffering
  // ------------------------------------------------------------
  localparam int unsigned HDR_BYTES = 4; // opcode plus three address bytes
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [2:0] BIT_LAST = 3'h7; // bit 7 goes first, bit 0 last
  localparam logic [9:0] FRAME_CNT_RESET = 10'h000;
  localparam logic [9:0] PAGE_END_CNT = 10'h104; // header plus one page

  // ------------------------------------------------------------
  // link state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SFI_IDLE = 2'b00,
    SFI_XFER = 2'b01,
    SFI_HOLD = 2'b10
  } sfi_state_type;

  // one received byte with a marker for the opcode position
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } sfi_byte_type;

endpackage

// >>> sfi_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// serial host model, mode 0 or mode 3
// ----------------------------------------
module sfi_host_model (
  input wire logic clk,
  input wire logic so_pin,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  // everything idle and deselected at time zero
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clock parks at its idle level before select, which sets the mode
  task automatic start(input logic m3);
    sck = m3;
    tick(2);
    cs_n = 1'b0;
    tick(5);
  endtask

  // one unit msb first; a hold is wrapped round bit hold_at
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      input int hold_at, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      sck = 1'b0;
      si = tx[i];
      if (i == hold_at) begin
        hold_n = 1'b0;
        tick(5);
        sck = 1'b1; // stray pulse must be ignored
        si = ~si;
        tick(5);
        sck = 1'b0;
        tick(5);
        hold_n = 1'b1;
        si = tx[i];
      end
      tick(5);
      sck = 1'b1;
      rx[i] = so_pin;
      tick(5);
    end
  endtask

  // erase and program waits and busy polling are left to the user
  // of this model; frames here never start a long operation
  // whole or partial units; released data line never keeps its last value
  task automatic stop(input logic m3);
    sck = m3;
    tick(5);
    cs_n = 1'b1;
    si = ~si;
    tick(5);
  endtask
endmodule

// >>> sfi_spi_slave_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// testbench for the serial front end
// ----------------------------------------
module sfi_spi_slave_tb;
  import sfi_pkg::*;
  logic clk = 1'b0, reset = 1'b1, lock = 1'b0, wp_n = 1'b1;
  logic tx_en = 1'b0, rx_ready = 1'b1;
  logic [7:0] tx_data;
  logic sck, cs_n, si, hold_n, so, so_oe, lock_act, tx_take, rx_valid;
  logic selected, mode3, page_end, overrun, oe_in_hold = 1'b0;
  logic [1:0] hold_hist = 2'b11;
  sfi_byte_type rx_byte;
  sfi_byte_type got[$];
  int miscompares = 0, n_checks = 0, cycles = 0, takes = 0;
  logic [8:0] rows [4] = '{9'h0a5, 9'h13c, 9'h080, 9'h101};
  // nobody drives the pin while its enable is low
  wire so_pin = so_oe ? so : 1'bz;

  always #2 clk = ~clk;

  sfi_spi_slave dut (
    .CLK(clk), .RESET(reset), .SCK(sck), .CS_N(cs_n), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe),
    .STATUS_WRITE_LOCK(lock), .LOCK_ACTIVE(lock_act), .TX_EN(tx_en),
    .TX_DATA(tx_data), .TX_TAKE(tx_take), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_BYTE(rx_byte), .SELECTED(selected),
    .MODE3(mode3), .PAGE_END(page_end), .OVERRUN(overrun)
  );
  sfi_host_model host (.clk(clk), .so_pin(so_pin), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // frame of n bytes counting up from b0
  task automatic frame(input logic m3, input logic [7:0] b0,
                       input int n);
    logic [7:0] rx;
    host.start(m3);
    check("selected", selected, 1);
    check("mode3", mode3, m3);
    for (int i = 0; i < n; i++) host.xfer(b0 + 8'(i), 8, -1, rx);
    host.stop(m3);
  endtask

  // ----------------------------------------
  // monitors: popped bytes, take pulses, output during hold, timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_byte);
    if (tx_take === 1'b1) takes <= takes + 1;
    if (hold_hist == 2'b00 && so_oe !== 1'b0) oe_in_hold <= 1'b1;
    hold_hist <= {hold_hist[0], hold_n};
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] rx;
    int t0;
    tx_data = 8'h00;
    tick(8);
    reset = 1'b0;
    tick(3);
    // single bytes in both modes
    foreach (rows[k]) begin
      got.delete();
      frame(rows[k][8], rows[k][7:0], 1);
      tick(10);
      check("rx count", got.size(), 1);
      check("rx byte", got[0], {1'b1, rows[k][7:0]});
    end
    // reset in mid-run clears the outputs
    reset = 1'b1;
    tick(2);
    check("rst sel", {so_oe, rx_valid, selected, page_end}, 0);
    reset = 1'b0;
    tick(3);
    // lock only bites with protect low
    for (int w = 0; w < 4; w++) begin
      {lock, wp_n} = w[1:0];
      tick(2);
      check("lock", lock_act, w == 2);
    end
    // read with a hold in both directions
    tx_data = 8'hc3;
    got.delete();
    t0 = takes;
    host.start(1'b0);
    host.xfer(8'h03, 8, 4, rx);
    tx_en = 1'b1;
    host.xfer(8'h00, 8, 3, rx);
    check("oe on", so_oe, 1);
    host.stop(1'b0);
    check("read", rx, 8'hc3);
    check("oe off", so_oe, 0);
    check("takes", takes - t0, 2);
    check("held rx", got[0], {1'b1, 8'h03});
    check("oe in hold", oe_in_hold, 0);
    tx_en = 1'b0;
    // partial byte and stray clocks while deselected are dropped
    got.delete();
    host.start(1'b0);
    host.xfer(8'hff, 4, -1, rx);
    host.stop(1'b0);
    host.xfer(8'hff, 8, -1, rx);
    frame(1'b0, 8'h5a, 1);
    tick(10);
    check("drop cnt", got.size(), 1);
    check("drop byte", got[0], {1'b1, 8'h5a});
    // fill the fifo past full with the reader stalled, then drain
    rx_ready = 1'b0;
    got.delete();
    frame(1'b0, 8'h10, 20);
    check("overrun", overrun, 1);
    rx_ready = 1'b1;
    tick(40);
    check("kept", got.size() >= FIFO_DEPTH, 1);
    foreach (got[i]) check("order", got[i], {i == 0, 8'h10 + 8'(i)});
    // one page plus header, overrun cleared by the new select
    host.start(1'b0);
    check("ovr clr", overrun, 0);
    for (int i = 0; i < 260; i++) begin
      if (i == 259) check("page early", page_end, 0);
      host.xfer(8'(i), 8, -1, rx);
    end
    tick(3);
    check("page end", page_end, 1);
    host.stop(1'b0);
    check("page clr", page_end, 0);
    end_of_test();
  end
endmodule
